// ### ccp_pkg.sv
// constants and types of the carrier compare pwm unit
package ccp_pkg;

  // ----------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  REG_CTRL  = 8'h00;
  localparam logic [7:0]  REG_STEP  = 8'h04;
  localparam logic [7:0]  REG_DEAD  = 8'h08;
  localparam logic [7:0]  REG_REP   = 8'h0C;
  localparam logic [7:0]  REG_CHCFG = 8'h10;
  localparam logic [7:0]  REG_MOD0  = 8'h14;
  localparam logic [7:0]  REG_STAT  = 8'h20;
  localparam logic [7:0]  REG_CARR  = 8'h24;
  localparam logic [7:0]  REG_STRIDE = 8'h04;

  // ----------------------------------------------------------
  // field layout
  // ----------------------------------------------------------
  localparam int CTRL_W     = 8;
  localparam int CFG_POL_LO = 4;
  localparam int STAT_BRK   = 0;
  localparam int STAT_DIR   = 1;

  // ----------------------------------------------------------
  // carrier arithmetic: 1.0 is 17'h10000
  // ----------------------------------------------------------
  localparam int          CAR_W        = 17;
  localparam logic [16:0] CAR_ONE      = 17'h10000;
  localparam logic [16:0] CAR_ZERO     = 17'h00000;
  localparam int          FSCALE_FRAC  = 8;
  localparam logic [15:0] FSCALE_UNITY = 16'h0100;

  // ----------------------------------------------------------
  // reset values
  // ----------------------------------------------------------
  localparam logic [15:0] STEP_RST = 16'h0100;
  localparam logic [15:0] DEAD_RST = 16'h0010;
  localparam logic [7:0]  REP_RST  = 8'h01;
  localparam logic [7:0]  CFG_RST  = 8'h70;

  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    BRK_OFF  = 2'h0,
    BRK_LOW  = 2'h1,
    BRK_HIGH = 2'h2
  } ccp_brk_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } ccp_dir_t;

  // bit 0 is run, bit 7 is trigger event select
  typedef struct packed {
    logic     evt_ovf;
    ccp_brk_t brk_mode;
    logic     task_en;
    logic     adc_en;
    logic     fvar;
    logic     sym;
    logic     run;
  } ccp_ctrl_t;

  typedef struct packed {
    logic adc;
    logic task_t;
  } ccp_trig_t;

endpackage

// ### ccp_carrier_pwm.sv
// carrier compare pwm generator with avalon-mm register slave
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

// Overview of operation
// - output active while index exceeds carrier
// - carrier starts at zero, spans zero to one
// - frequency is nominal times scaling input
// - one scaling input shared by all channels
// - variation off means nominal frequency
// - three channels, single or complementary each
// - dead time between complementary edges
// - carrier is sawtooth or symmetrical triangle
// - polarity sets the active output level
// - triggers follow carrier events after repetitions
// - repetition period counts events per trigger
// - symmetric carrier triggers at selected extreme
// - minimum is underflow, maximum is overflow
// - converter trigger has its own enable
// - control task trigger has its own enable
// - break event forces all outputs passive
// - active low break acts on falling edge
// - active high break acts on rising edge
// - break disabled ignores the break pin
// - enable input low holds outputs passive
module ccp_carrier_pwm #(
  parameter int NCH = 3
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // avalon-mm slave
  input  wire logic [ccp_pkg::ADDR_W-1:0] address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  // control logic side
  input  wire logic [15:0]               freq_scale,
  input  wire logic                      pwm_enable,
  // break pin
  input  wire logic                      break_pin,
  // power stage
  output logic      [NCH-1:0]            pwm_hi,
  output logic      [NCH-1:0]            pwm_lo,
  output ccp_pkg::ccp_trig_t             trig
);

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  ccp_pkg::ccp_ctrl_t ctrl_r;
  logic [15:0]        step_r;
  logic [15:0]        dead_r;
  logic [7:0]         rep_r;
  logic [7:0]         cfg_r;
  logic [16:0]        mod_r [NCH];
  logic               ack_r;
  logic [31:0]        rdata_r;

  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  wire       req      = read | write;
  wire       wr_go    = write & ack_r;
  wire       sel_ctrl = address == ccp_pkg::REG_CTRL;
  wire       sel_step = address == ccp_pkg::REG_STEP;
  wire       sel_dead = address == ccp_pkg::REG_DEAD;
  wire       sel_rep  = address == ccp_pkg::REG_REP;
  wire       sel_cfg  = address == ccp_pkg::REG_CHCFG;
  wire       sel_stat = address == ccp_pkg::REG_STAT;
  wire       sel_carr = address == ccp_pkg::REG_CARR;
  wire       brk_clr  = wr_go & sel_stat & writedata[ccp_pkg::STAT_BRK];
  wire [NCH-1:0] comp_en = cfg_r[NCH-1:0];
  wire [NCH-1:0] pol     = cfg_r[ccp_pkg::CFG_POL_LO +: NCH];

  assign waitrequest = req & ~ack_r;
  assign readdata    = rdata_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ----------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= '0;
      step_r <= ccp_pkg::STEP_RST;
      dead_r <= ccp_pkg::DEAD_RST;
      rep_r  <= ccp_pkg::REP_RST;
      cfg_r  <= ccp_pkg::CFG_RST;
    end else if (wr_go) begin
      if (sel_ctrl) ctrl_r <= writedata[ccp_pkg::CTRL_W-1:0];
      if (sel_step) step_r <= writedata[15:0];
      if (sel_dead) dead_r <= writedata[15:0];
      if (sel_rep)  rep_r  <= writedata[7:0];
      if (sel_cfg)  cfg_r  <= writedata[7:0];
    end
  end

  // ----------------------------------------------------------
  // carrier
  // ----------------------------------------------------------
  ccp_pkg::ccp_dir_t dir_r;
  logic [16:0] car_r;
  logic [15:0] step_use_r;
  logic [16:0] thr_r [NCH];
  logic        ovf_ev;
  logic        unf_ev;
  logic        bound;

  // product widened so no scale value can overflow
  wire [31:0] scaled  = step_r * freq_scale;
  wire [15:0] step_fv = scaled[ccp_pkg::FSCALE_FRAC +: 16];
  wire [15:0] step_nx = ctrl_r.fvar ? step_fv : step_r;
  wire [17:0] sum     = {1'b0, car_r} + {2'b00, step_use_r};
  wire        at_top  = sum >= {1'b0, ccp_pkg::CAR_ONE};
  wire        at_bot  = car_r <= {1'b0, step_use_r};
  wire        going_up = dir_r == ccp_pkg::DIR_UP;

  assign ovf_ev = ctrl_r.run & going_up & at_top;
  assign unf_ev = ctrl_r.run & (ctrl_r.sym ? (~going_up & at_bot)
                                           : at_top);
  // stopped counts as a boundary so values load before start
  assign bound  = ~ctrl_r.run | unf_ev;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      car_r <= ccp_pkg::CAR_ZERO;
      dir_r <= ccp_pkg::DIR_UP;
    end else if (!ctrl_r.run) begin
      car_r <= ccp_pkg::CAR_ZERO;
      dir_r <= ccp_pkg::DIR_UP;
    end else begin
      unique case (dir_r)
        ccp_pkg::DIR_UP: begin
          if (!at_top) begin
            car_r <= sum[16:0];
          end else if (ctrl_r.sym) begin
            car_r <= ccp_pkg::CAR_ONE;
            dir_r <= ccp_pkg::DIR_DOWN;
          end else begin
            car_r <= sum[16:0] - ccp_pkg::CAR_ONE;
          end
        end
        ccp_pkg::DIR_DOWN: begin
          if (at_bot) begin
            car_r <= ccp_pkg::CAR_ZERO;
            dir_r <= ccp_pkg::DIR_UP;
          end else begin
            car_r <= car_r - {1'b0, step_use_r};
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      step_use_r <= ccp_pkg::STEP_RST;
    end else if (bound) begin
      step_use_r <= step_nx;
    end
  end

  // ----------------------------------------------------------
  // repetition counter and triggers
  // ----------------------------------------------------------
  logic [7:0] rep_cnt_r;
  ccp_pkg::ccp_trig_t trig_r;
  wire        ev_sel = ctrl_r.evt_ovf ? ovf_ev : unf_ev;
  wire [8:0]  cnt_inc = {1'b0, rep_cnt_r} + 9'h001;
  // a period of zero behaves as one
  wire        fire   = ev_sel & (cnt_inc >= {1'b0, rep_r});

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rep_cnt_r <= 8'h00;
      trig_r    <= '0;
    end else begin
      if (!ctrl_r.run || fire) begin
        rep_cnt_r <= 8'h00;
      end else if (ev_sel) begin
        rep_cnt_r <= cnt_inc[7:0];
      end
      trig_r.adc    <= fire & ctrl_r.adc_en;
      trig_r.task_t <= fire & ctrl_r.task_en;
    end
  end

  assign trig = trig_r;

  // ----------------------------------------------------------
  // break input
  // ----------------------------------------------------------
  logic brk_s1;
  logic brk_s2;
  logic brk_d;
  logic brk_lat_r;

  wire brk_fall = brk_d & ~brk_s2;
  wire brk_rise = ~brk_d & brk_s2;
  wire brk_ev   = (ctrl_r.brk_mode == ccp_pkg::BRK_LOW  & brk_fall) |
                  (ctrl_r.brk_mode == ccp_pkg::BRK_HIGH & brk_rise);
  wire brk_act  = brk_lat_r & (ctrl_r.brk_mode != ccp_pkg::BRK_OFF);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      brk_s1    <= 1'b0;
      brk_s2    <= 1'b0;
      brk_d     <= 1'b0;
      brk_lat_r <= 1'b0;
    end else begin
      brk_s1    <= break_pin;
      brk_s2    <= brk_s1;
      brk_d     <= brk_s2;
      // a new edge wins over a clear in the same cycle
      brk_lat_r <= brk_ev | (brk_lat_r & ~brk_clr);
    end
  end

  wire passive = ~ctrl_r.run | ~pwm_enable | brk_act;

  // ----------------------------------------------------------
  // per channel compare, dead time and output stage
  // ----------------------------------------------------------
  logic [NCH-1:0] raw_r;
  logic [NCH-1:0] hi_act;
  logic [NCH-1:0] lo_act;
  logic [NCH-1:0] hi_r;
  logic [NCH-1:0] lo_r;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [15:0] dt_r;
      wire [7:0]   mod_off = ccp_pkg::REG_MOD0 +
                             8'(g) * ccp_pkg::REG_STRIDE;
      wire         sel_mod = address == mod_off;
      wire         raw     = thr_r[g] > car_r;
      wire         settled = dt_r == 16'h0000;

      // both sides idle until the gap expires
      assign hi_act[g] = raw_r[g] & (settled | ~comp_en[g]);
      assign lo_act[g] = ~raw_r[g] & settled & comp_en[g];

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          mod_r[g] <= ccp_pkg::CAR_ZERO;
          thr_r[g] <= ccp_pkg::CAR_ZERO;
          raw_r[g] <= 1'b0;
          dt_r     <= 16'h0000;
          hi_r[g]  <= 1'b0;
          lo_r[g]  <= 1'b0;
        end else begin
          if (wr_go && sel_mod) mod_r[g] <= writedata[16:0];
          if (bound) thr_r[g] <= mod_r[g];
          raw_r[g] <= raw;
          if (raw != raw_r[g]) begin
            dt_r <= dead_r;
          end else if (!settled) begin
            dt_r <= dt_r - 16'h0001;
          end
          hi_r[g] <= (hi_act[g] & ~passive) ? pol[g] : ~pol[g];
          lo_r[g] <= (lo_act[g] & ~passive) ? pol[g] : ~pol[g];
        end
      end
    end
  endgenerate

  assign pwm_hi = hi_r;
  assign pwm_lo = lo_r;

  // ----------------------------------------------------------
  // read mux
  // ----------------------------------------------------------
  logic [31:0] mod_rd;
  always_comb begin
    mod_rd = 32'h0000_0000;
    for (int i = 0; i < NCH; i++) begin
      if (address == ccp_pkg::REG_MOD0 + 8'(i) * ccp_pkg::REG_STRIDE)
        mod_rd = {15'h0000, mod_r[i]};
    end
  end

  wire [31:0] stat_rd = {30'h0000_0000, dir_r == ccp_pkg::DIR_DOWN,
                         brk_lat_r};
  wire [31:0] rd_mux =
      sel_ctrl ? {24'h000000, ctrl_r} :
      sel_step ? {16'h0000, step_r} :
      sel_dead ? {16'h0000, dead_r} :
      sel_rep  ? {24'h000000, rep_r} :
      sel_cfg  ? {24'h000000, cfg_r} :
      sel_stat ? stat_rd :
      sel_carr ? {15'h0000, car_r} : mod_rd;

  // unmapped addresses read as zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (read && !ack_r) begin
      rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  passive_hi_a: assert property (
    passive |=> pwm_hi == ~$past(pol))
    else $error("primary not passive while forced");

  passive_lo_a: assert property (
    !pwm_enable |=> pwm_lo == ~$past(pol))
    else $error("secondary not passive with enable low");

  carrier_span_a: assert property (
    car_r <= ccp_pkg::CAR_ONE)
    else $error("carrier above one");

  dead_gap_a: assert property (
    ($past(comp_en) & ~(pwm_hi ^ $past(pol)) & ~(pwm_lo ^ $past(pol))) == '0)
    else $error("both outputs of a pair active");

  dead_len_a: assert property (
    (comp_en[0] && raw_r[0] != $past(raw_r[0]) && dead_r != 0)
      |-> !hi_act[0] && !lo_act[0])
    else $error("no dead time after compare change");

  adc_cause_a: assert property (
    trig.adc |-> $past(ev_sel) && $past(ctrl_r.adc_en))
    else $error("converter trigger without event");

  rep_count_a: assert property (
    (ctrl_r.run && rep_r == 8'h02 && fire)
      |-> rep_cnt_r == 8'h01 ##1 rep_cnt_r == 8'h00)
    else $error("repetition count wrong");

  sym_floor_a: assert property (
    (ctrl_r.sym && dir_r == ccp_pkg::DIR_DOWN && unf_ev)
      |=> car_r == ccp_pkg::CAR_ZERO && dir_r == ccp_pkg::DIR_UP)
    else $error("underflow did not reach zero");

  brk_hold_a: assert property (
    (brk_lat_r && !brk_clr) |=> brk_lat_r)
    else $error("break latch dropped");

  thr_bound_a: assert property (
    !$stable(thr_r[0]) |-> $past(bound))
    else $error("index changed inside a period");

  bus_wait_a: assert property (
    (req && !ack_r) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer timing wrong");

endmodule // ccp_carrier_pwm

// ### ccp_gate_model.sv
// gate driver stand-in that watches the pwm legs for shoot-through
`timescale 1ns/1ps
module ccp_gate_model #(
  parameter int NCH = 3
) (
  // clock
  input  wire logic           ref_clk,
  // pwm pins from the generator
  input  wire logic [NCH-1:0] pwm_hi,
  input  wire logic [NCH-1:0] pwm_lo,
  // legs wired as active-high complementary pairs
  input  wire logic [NCH-1:0] pair_on,
  // cycles with both switches of one leg on
  output int                  shoot_cnt
);
  // ----------------------------------------------------------
  // leg monitor
  // ----------------------------------------------------------
  initial shoot_cnt = 0;
  // both gates on shorts the rail, so dead time has to cover every edge
  always @(posedge ref_clk) begin
    if (|(pwm_hi & pwm_lo & pair_on)) shoot_cnt <= shoot_cnt + 1;
  end
endmodule // ccp_gate_model

// ### tb_top.sv
// self-checking testbench of the carrier compare pwm unit
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------
  logic               ref_clk, rst, read, write;
  logic               pwm_enable, break_pin, waitrequest, hi_at_trig;
  logic [7:0]         address;
  logic [31:0]        writedata, readdata, rd;
  logic [15:0]        freq_scale;
  logic [2:0]         pwm_hi, pwm_lo;
  ccp_pkg::ccp_trig_t trig;
  int                 err_total, checks, shoot_cnt, na, nt;
  int                 hc[3], lc[3];
  logic [7:0]         ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                8'h24, 8'h3C};
  logic [31:0]        rv[7] = '{32'h0, 32'h100, 32'h10, 32'h1, 32'h70,
                                32'h0, 32'h0};

  ccp_carrier_pwm #(.NCH(3)) u_ccp_carrier_pwm (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .freq_scale(freq_scale),
    .pwm_enable(pwm_enable), .break_pin(break_pin), .pwm_hi(pwm_hi),
    .pwm_lo(pwm_lo), .trig(trig));

  ccp_gate_model #(.NCH(3)) u_ccp_gate_model (
    .ref_clk(ref_clk), .pwm_hi(pwm_hi), .pwm_lo(pwm_lo),
    .pair_on(3'h1), .shoot_cnt(shoot_cnt));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bad(input string m);
    err_total++;
    $display("BAD t=%0t %s", $time, m);
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) bad($sformatf("value %h expected %h", g, e));
  endtask

  task automatic chk_cnt(input int g, input int e);
    checks++;
    if (g != e) bad($sformatf("count %0d expected %0d", g, e));
  endtask

  // request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      bad("bus timeout");
      tally_and_finish();
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic count(input int n);
    hc = '{0, 0, 0};
    lc = '{0, 0, 0};
    na = 0;
    nt = 0;
    repeat (n) begin
      @(posedge ref_clk);
      for (int i = 0; i < 3; i++) begin
        hc[i] += int'(pwm_hi[i] === 1'b1);
        lc[i] += int'(pwm_lo[i] === 1'b1);
      end
      if (trig.adc === 1'b1) begin
        na++;
        hi_at_trig = pwm_hi[0];
      end
      nt += int'(trig.task_t === 1'b1);
    end
  endtask

  task automatic expect_pins(input int h0, h1, h2, l0, l1, l2);
    chk_cnt(hc[0], h0);
    chk_cnt(hc[1], h1);
    chk_cnt(hc[2], h2);
    chk_cnt(lc[0], l0);
    chk_cnt(lc[1], l1);
    chk_cnt(lc[2], l2);
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    bad("run timeout");
    tally_and_finish();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    err_total = 0;
    checks = 0;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    pwm_enable = 1'b1;
    break_pin = 1'b1;
    freq_scale = 16'h0200;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    chk_reg({24'h0, trig, pwm_lo, pwm_hi}, 32'h0);
    bus(1'b1, 8'h3C, 32'hFF);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      chk_reg(rd, rv[i]);
    end
    // sawtooth of 16 clocks, ch2 active low
    bus(1'b1, ccp_pkg::REG_STEP, 32'h1000);
    bus(1'b1, ccp_pkg::REG_MOD0, 32'h8000);
    bus(1'b1, ccp_pkg::REG_MOD0 + 8'h08, 32'h4000);
    bus(1'b1, ccp_pkg::REG_CHCFG, 32'h30);
    bus(1'b1, ccp_pkg::REG_DEAD, 32'h2);
    bus(1'b1, ccp_pkg::REG_CTRL, 32'h09);
    settle(40);
    count(64);
    expect_pins(32, 0, 48, 0, 0, 64);
    chk_cnt(na, 4);
    chk_cnt(nt, 0);
    bus(1'b1, ccp_pkg::REG_CTRL, 32'h0D);
    settle(40);
    count(64);
    expect_pins(32, 0, 48, 0, 0, 64);
    chk_cnt(na, 8);
    bus(1'b1, ccp_pkg::REG_CTRL, 32'h09);
    bus(1'b1, ccp_pkg::REG_CHCFG, 32'h31);
    settle(40);
    count(64);
    expect_pins(24, 0, 48, 24, 0, 64);
    chk_cnt(shoot_cnt, 0);
    // symmetric carrier of 32 clocks, triggers every second underflow
    bus(1'b1, ccp_pkg::REG_CHCFG, 32'h30);
    bus(1'b1, ccp_pkg::REG_REP, 32'h2);
    bus(1'b1, ccp_pkg::REG_CTRL, 32'h1B);
    settle(80);
    count(128);
    chk_cnt(na, 2);
    chk_cnt(nt, 2);
    chk_reg({31'h0, hi_at_trig}, 32'h1);
    bus(1'b1, ccp_pkg::REG_REP, 32'h1);
    bus(1'b1, ccp_pkg::REG_CTRL, 32'h9B);
    settle(80);
    count(128);
    chk_cnt(nt, 4);
    chk_reg({31'h0, hi_at_trig}, 32'h0);
    // active-low break, then active-high, then disabled
    bus(1'b1, ccp_pkg::REG_CTRL, 32'h29);
    settle(40);
    break_pin <= 1'b0;
    settle(6);
    count(32);
    expect_pins(0, 0, 32, 0, 0, 32);
    bus(1'b0, ccp_pkg::REG_STAT, 32'h0);
    chk_reg(rd & 32'h1, 32'h1);
    break_pin <= 1'b1;
    bus(1'b1, ccp_pkg::REG_STAT, 32'h1);
    bus(1'b1, ccp_pkg::REG_CTRL, 32'h49);
    settle(40);
    count(64);
    expect_pins(32, 0, 48, 0, 0, 64);
    break_pin <= 1'b0;
    settle(10);
    break_pin <= 1'b1;
    settle(6);
    count(32);
    expect_pins(0, 0, 32, 0, 0, 32);
    bus(1'b1, ccp_pkg::REG_CTRL, 32'h09);
    break_pin <= 1'b0;
    settle(40);
    count(64);
    expect_pins(32, 0, 48, 0, 0, 64);
    pwm_enable <= 1'b0;
    settle(3);
    count(32);
    expect_pins(0, 0, 32, 0, 0, 32);
    tally_and_finish();
  end
endmodule // tb_top
